// ==== core/wdg_map.vh ====
// Register map, field positions, reset values and timing counts of the watchdog.
// Assumes inclusion by bare name from the design files of this block.
`ifndef WDG_MAP_VH
`define WDG_MAP_VH

// Register port geometry
`define WDG_ADDR_W 4
`define WDG_DATA_W 8

// Register offsets on the register port
`define WDG_OFS_CONTROL 4'h0
`define WDG_OFS_CAUSE 4'h1

// watchdog_control fields
`define WDG_BIT_IRQ_FLAG 7
`define WDG_BIT_IRQ_EN 6
`define WDG_BIT_SEL3 5
`define WDG_BIT_UNLOCK 4
`define WDG_BIT_ENABLE 3
`define WDG_BIT_SEL2 2
`define WDG_BIT_SEL0 0

// reset_cause_register fields
`define WDG_BIT_CAUSE 3

// Reset values
`define WDG_CONTROL_RST 8'h00
`define WDG_SEL_RST 4'h0
`define WDG_CAUSE_RST 1'b0

// Timing
`define WDG_UNLOCK_CYCLES 3'h4
`define WDG_OSC_KHZ 128
`define WDG_BASE_CYCLES 2048
`define WDG_CNT_W 20
`define WDG_SEL_MAX 4'h9

`endif

// ==== core/wdg_osc_edge.v ====
// Rising-edge detector for the low-frequency watchdog oscillator.
// Assumes the oscillator level arrives synchronous to clk_sys_in.
`timescale 1ns/1ps
`default_nettype none

module wdg_osc_edge (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire osc_level_in,
    output wire osc_tick_out
);

    reg osc_prev_reg;

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_prev_reg <= 1'b0;
        end else begin
            osc_prev_reg <= osc_level_in;
        end
    end

    // One system cycle per oscillator period
    assign osc_tick_out = osc_level_in & ~osc_prev_reg;

endmodule

`default_nettype wire

// ==== core/wdg_timeout_counter.v ====
// Oscillator-cycle counter with a selectable power-of-two terminal count.
// Assumes one tick per oscillator cycle and a synchronous clear from the owner.
`timescale 1ns/1ps
`default_nettype none

module wdg_timeout_counter #(
    parameter CNT_W = 20,
    parameter BASE_CYCLES = 2048,
    parameter [3:0] SEL_MAX = 4'h9
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire tick_in,
    input wire clear_in,
    input wire run_in,
    input wire [3:0] sel_in,
    output wire timeout_out
);

    reg [CNT_W-1:0] count_reg;
    reg [CNT_W-1:0] count_next;
    wire [3:0] sel_eff;
    wire [31:0] limit_wide;
    wire [CNT_W-1:0] last_count;
    wire hit;

    // Reserved codes fall back to the longest documented time-out
    assign sel_eff = (sel_in > SEL_MAX) ? SEL_MAX : sel_in;
    assign limit_wide = BASE_CYCLES << sel_eff;
    assign last_count = limit_wide[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
    assign hit = run_in & ~clear_in & tick_in & (count_reg == last_count);
    assign timeout_out = hit;

    always @* begin
        count_next = count_reg;
        if (clear_in || !run_in) begin
            count_next = {CNT_W{1'b0}};
        end else if (hit) begin
            count_next = {CNT_W{1'b0}};
        end else if (tick_in) begin
            count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= {CNT_W{1'b0}};
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

`default_nettype wire

// ==== core/wdg_top.v ====
// Watchdog timer with timed configuration unlock and fuse-selected safety level.
// Assumes a CPU register port with read data one cycle after the read strobe,
// a 25 MHz system clock and a 128 kHz oscillator level synchronous to it.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_map.vh"

module wdg_top #(
    parameter BASE_CYCLES = `WDG_BASE_CYCLES,
    parameter CNT_W = `WDG_CNT_W
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire [`WDG_ADDR_W-1:0] addr_in,
    input wire [`WDG_DATA_W-1:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output wire [`WDG_DATA_W-1:0] rdata_out,
    input wire osc_level_in,
    input wire safety_level_fuse_in,
    input wire processor_status_irq_in,
    input wire irq_ack_in,
    input wire guard_restart_instruction_in,
    output wire irq_req_out,
    output wire guard_reset_out,
    output wire guard_running_out
);

    // Control state
    reg irq_flag_reg;
    reg irq_flag_next;
    reg irq_en_reg;
    reg irq_en_next;
    reg [2:0] unlock_cnt_reg;
    reg [2:0] unlock_cnt_next;
    reg enable_reg;
    reg enable_next;
    reg [3:0] sel_reg;
    reg [3:0] sel_next;
    reg cause_reg;
    reg cause_next;
    reg reset_pulse_reg;
    reg [`WDG_DATA_W-1:0] rdata_reg;
    reg [`WDG_DATA_W-1:0] rdata_next;

    wire level2;
    wire unlocked;
    wire enable_eff;
    wire running;
    wire osc_tick;
    wire timeout;
    wire irq_action;
    wire reset_action;
    wire counter_clear;
    wire wr_ctl;
    wire wr_cause;
    wire wr_unlock_req;
    wire [3:0] wr_sel;
    wire [`WDG_DATA_W-1:0] control_view;
    wire [`WDG_DATA_W-1:0] cause_view;
    wire [`WDG_DATA_W-1:0] control_rst;
    wire wr_flag_clear;
    wire wr_second;

    // Programmed fuse selects safety level two
    assign level2 = safety_level_fuse_in;
    assign unlocked = (unlock_cnt_reg != 3'h0);

    // Level two forces the watchdog on; level one lets the cause flag hold it on
    assign enable_eff = level2 | enable_reg | cause_reg;

    // Counter runs whenever either enable bit is set
    assign running = enable_eff | irq_en_reg;

    assign wr_ctl = wr_in & (addr_in == `WDG_OFS_CONTROL);
    assign wr_cause = wr_in & (addr_in == `WDG_OFS_CAUSE);
    assign wr_unlock_req = wdata_in[`WDG_BIT_UNLOCK] & wdata_in[`WDG_BIT_ENABLE];
    assign wr_sel = {wdata_in[`WDG_BIT_SEL3], wdata_in[`WDG_BIT_SEL2:`WDG_BIT_SEL0]};

    // Reset image of the control register, source of the two enable bits a watchdog reset restores
    assign control_rst = `WDG_CONTROL_RST;
    // Writing one to the flag clears it
    assign wr_flag_clear = wr_ctl & wdata_in[`WDG_BIT_IRQ_FLAG];
    // Second write of the timed sequence: window open and unlock bit written zero
    assign wr_second = wr_ctl & unlocked & ~wdata_in[`WDG_BIT_UNLOCK];

    // Own reset pulse restarts the count like any chip reset
    assign counter_clear = guard_restart_instruction_in | reset_pulse_reg;

    wdg_osc_edge u_osc_edge (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .osc_level_in(osc_level_in),
        .osc_tick_out(osc_tick)
    );

    wdg_timeout_counter #(
        .CNT_W(CNT_W),
        .BASE_CYCLES(BASE_CYCLES),
        .SEL_MAX(`WDG_SEL_MAX)
    ) u_counter (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .tick_in(osc_tick),
        .clear_in(counter_clear),
        .run_in(running),
        .sel_in(sel_reg),
        .timeout_out(timeout)
    );

    // Interrupt takes priority over reset when both enables are set
    assign irq_action = timeout & irq_en_reg;
    assign reset_action = timeout & ~irq_en_reg & enable_eff;

    // Interrupt time-out flag
    always @* begin
        irq_flag_next = irq_flag_reg;
        if (irq_ack_in) begin
            irq_flag_next = 1'b0;
        end
        if (wr_flag_clear) begin
            irq_flag_next = 1'b0;
        end
        // A time-out in the clearing cycle is not lost
        if (irq_action) begin
            irq_flag_next = 1'b1;
        end
    end

    // Interrupt enable
    always @* begin
        irq_en_next = irq_en_reg;
        if (wr_ctl) begin
            irq_en_next = wdata_in[`WDG_BIT_IRQ_EN];
        end
        // Next time-out resets unless software re-arms the interrupt
        if (irq_action && enable_eff) begin
            irq_en_next = 1'b0;
        end
        if (reset_action) begin
            irq_en_next = control_rst[`WDG_BIT_IRQ_EN];
        end
    end

    // Change-unlock window, four cycles long
    // A write with unlock and enable both one loads the count; the window is
    // open while it is nonzero, so the next four cycles may carry the second write
    always @* begin
        unlock_cnt_next = unlock_cnt_reg;
        if (unlocked) begin
            unlock_cnt_next = unlock_cnt_reg - 3'h1;
        end
        if (wr_ctl) begin
            if (wr_unlock_req) begin
                unlock_cnt_next = `WDG_UNLOCK_CYCLES;
            end else if (unlocked) begin
                // Second write of the sequence uses up the window
                unlock_cnt_next = 3'h0;
            end
        end
        if (reset_action) begin
            unlock_cnt_next = 3'h0;
        end
    end

    // Enable bit
    // Setting needs no unlock; clearing needs the open window, level one and a
    // zero unlock bit, so a stray write cannot switch the guard off
    always @* begin
        enable_next = enable_reg;
        if (wr_ctl) begin
            if (wdata_in[`WDG_BIT_ENABLE]) begin
                enable_next = 1'b1;
            end else if (wr_second && !level2) begin
                enable_next = 1'b0;
            end
        end
        // At level one the stored enable is held set while the reset cause is pending
        if (cause_reg && !level2) begin
            enable_next = 1'b1;
        end
        if (reset_action) begin
            enable_next = control_rst[`WDG_BIT_ENABLE];
        end
    end

    // Time-out select
    always @* begin
        sel_next = sel_reg;
        if (wr_second) begin
            sel_next = wr_sel;
        end
        if (reset_action) begin
            sel_next = `WDG_SEL_RST;
        end
    end

    // Reset cause flag; the hardware set wins over a software clear
    always @* begin
        cause_next = cause_reg;
        if (wr_cause && !wdata_in[`WDG_BIT_CAUSE]) begin
            cause_next = 1'b0;
        end
        if (reset_action) begin
            cause_next = 1'b1;
        end
    end

    // Register read views; reserved bits read as zero
    assign control_view = {irq_flag_reg, irq_en_reg, sel_reg[3], unlocked,
                           enable_eff, sel_reg[2:0]};
    assign cause_view = {4'h0, cause_reg, 3'h0};

    always @* begin
        rdata_next = 8'h00;
        if (rd_in) begin
            case (addr_in)
                `WDG_OFS_CONTROL: begin
                    rdata_next = control_view;
                end
                `WDG_OFS_CAUSE: begin
                    rdata_next = cause_view;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    // Interrupt flag and enable
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_flag_reg <= 1'b0;
            irq_en_reg <= 1'b0;
        end else begin
            irq_flag_reg <= irq_flag_next;
            irq_en_reg <= irq_en_next;
        end
    end

    // Timed unlock window
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            unlock_cnt_reg <= 3'h0;
        end else begin
            unlock_cnt_reg <= unlock_cnt_next;
        end
    end

    // Configuration and reset cause
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_reg <= 1'b0;
            sel_reg <= `WDG_SEL_RST;
            cause_reg <= `WDG_CAUSE_RST;
        end else begin
            enable_reg <= enable_next;
            sel_reg <= sel_next;
            cause_reg <= cause_next;
        end
    end

    // Reset pulse and read data
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reset_pulse_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            reset_pulse_reg <= reset_action;
            rdata_reg <= rdata_next;
        end
    end

    assign irq_req_out = irq_flag_reg & irq_en_reg & processor_status_irq_in;
    assign guard_reset_out = reset_pulse_reg;
    assign guard_running_out = running;
    assign rdata_out = rdata_reg;

endmodule

`default_nettype wire

// ==== dv/wdg_monitor.sv ====
// Concurrent checks on the watchdog ports: register reads, unlock window, outputs.
// Assumes it is bound to wdg_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module wdg_monitor (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic safety_level_fuse_in,
    input wire logic processor_status_irq_in,
    input wire logic irq_req_out,
    input wire logic guard_reset_out,
    input wire logic guard_running_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    wire ctl_rd = rd_in && addr_in == 4'h0 && !wr_in;
    wire unlock_wr = wr_in && addr_in == 4'h0 && wdata_in[4] && wdata_in[3];
    a_reset_one_cycle: assert property (guard_reset_out |=> !guard_reset_out)
        else $error("reset pulse longer than one cycle");
    a_irq_needs_global: assert property (irq_req_out |-> processor_status_irq_in)
        else $error("interrupt request without global enable");
    a_read_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside its cycle");
    a_level2_runs: assert property (safety_level_fuse_in |-> guard_running_out)
        else $error("counter stopped at level two");
    a_level2_enable_one: assert property (ctl_rd && safety_level_fuse_in |=> rdata_out[3])
        else $error("enable read zero at level two");
    a_unlock_open: assert property (unlock_wr ##1 ctl_rd |=> rdata_out[4])
        else $error("unlock bit not set after unlock write");
    a_unlock_closes: assert property (unlock_wr ##1 !wr_in [*5] ##0 ctl_rd |=> !rdata_out[4])
        else $error("unlock bit still set after four cycles");
    a_running_mode: assert property (ctl_rd |=> $past(guard_running_out) == (rdata_out[3] | rdata_out[6]))
        else $error("running state disagrees with enable pair");
    a_cause_reserved: assert property (rd_in && addr_in == 4'h1 |=> (rdata_out & 8'hF7) == 8'h00)
        else $error("reserved cause bits not zero");
endmodule
bind wdg_top wdg_monitor wdg_monitor_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .safety_level_fuse_in(safety_level_fuse_in), .processor_status_irq_in(processor_status_irq_in),
    .irq_req_out(irq_req_out), .guard_reset_out(guard_reset_out),
    .guard_running_out(guard_running_out));
`default_nettype wire

// ==== dv/tb_wdg_top.sv ====
// Self-checking bench of the watchdog: time-out lengths, unlock window, safety levels.
// Assumes wdg_top with a shortened base count and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_wdg_top;
    localparam int BASE = 4;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic osc = 1'b0;
    logic fuse = 1'b0;
    logic gie = 1'b1;
    logic ack = 1'b0;
    logic restart = 1'b0;
    wire [7:0] rdata_out;
    wire irq_req_out;
    wire guard_reset_out;
    wire guard_running_out;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    int n;
    integer seed = 32'h586C4A20;
    logic [7:0] v;
    wdg_top #(.BASE_CYCLES(BASE)) wdg_top_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .osc_level_in(osc), .safety_level_fuse_in(fuse),
        .processor_status_irq_in(gie), .irq_ack_in(ack), .guard_restart_instruction_in(restart),
        .irq_req_out(irq_req_out), .guard_reset_out(guard_reset_out),
        .guard_running_out(guard_running_out));
    initial begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    // Oscillator rises every second system cycle
    always @(posedge clk_sys_in) begin
        osc <= ~osc;
        cycles <= cycles + 1;
        if (cycles > 90000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= w;
        rd_in <= !w;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1;
        v = rdata_out;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("register", e, v);
    endtask
    task automatic wait_sig(input int which);
        n = 0;
        while ((which ? guard_reset_out : irq_req_out) !== 1'b1 && n < 20000) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
    endtask
    task automatic reset_dut(input logic f);
        rst_n_in <= 1'b0;
        fuse <= f;
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        #1;
    endtask
    function automatic logic [7:0] sel_bits(input int s);
        return {2'b00, s[3], 2'b00, s[2:0]};
    endfunction
    initial begin
        reset_dut(1'b0);
        for (int s = 0; s < 16; s++) begin
            if (s > 10 && s < 15) continue;
            bus(1'b1, 4'h0, 8'h80);
            bus(1'b1, 4'h0, 8'h18);
            bus(1'b1, 4'h0, sel_bits(s) | 8'h40);
            wait_sig(0);
            ack <= 1'b1;
            @(posedge clk_sys_in);
            ack <= 1'b0;
            #1;
            chk("irq after ack", 0, irq_req_out);
            wait_sig(0);
            chk("time-out length", 2 * (BASE << ((s > 9) ? 9 : s)), n + 1);
            rc(4'h0, sel_bits(s) | 8'hC0);
            repeat (8) begin
                v = 8'($random(seed));
                gie <= v[0];
                @(posedge clk_sys_in);
                #1;
                chk("irq request", gie, irq_req_out);
            end
            gie <= 1'b1;
        end
        $display("select sweep done");
        bus(1'b1, 4'h0, 8'h80);
        bus(1'b1, 4'h0, 8'h18);
        bus(1'b1, 4'h0, 8'h06);
        bus(1'b1, 4'h0, 8'h4E);
        rc(4'h0, 8'h4E);
        n = 0;
        do begin
            bus(1'b0, 4'h0, 8'h00);
            n++;
        end while (v[7] !== 1'b1 && n < 2000);
        chk("control after time-out", 8'h8E, v);
        wait_sig(1);
        chk("reset pulse", 1, guard_reset_out);
        // The flag left by the earlier interrupt time-out is written clear before the level-one checks
        bus(1'b1, 4'h0, 8'h80);
        bus(1'b1, 4'h0, 8'h18);
        bus(1'b1, 4'h0, 8'h0E);
        rc(4'h1, 8'h08);
        rc(4'h0, 8'h0E);
        bus(1'b1, 4'h0, 8'h18);
        bus(1'b1, 4'h0, 8'h06);
        rc(4'h0, 8'h0E);
        bus(1'b1, 4'h1, 8'h00);
        rc(4'h1, 8'h00);
        bus(1'b1, 4'h0, 8'h18);
        for (int i = 1; i < 6; i++) begin
            rc(4'h0, (i < 5) ? 8'h1E : 8'h0E);
        end
        bus(1'b1, 4'h0, 8'h06);
        rc(4'h0, 8'h0E);
        bus(1'b1, 4'h0, 8'h18);
        bus(1'b1, 4'h0, 8'h00);
        rc(4'h0, 8'h00);
        chk("running", 0, guard_running_out);
        $display("level one sequence done");
        reset_dut(1'b1);
        repeat (20) begin
            restart <= 1'b1;
            @(posedge clk_sys_in);
            #1;
            chk("reset while restarted", 0, guard_reset_out);
        end
        restart <= 1'b0;
        bus(1'b1, 4'h0, 8'h18);
        bus(1'b1, 4'h0, 8'h21);
        rc(4'h0, 8'h29);
        rc(4'h1, 8'h00);
        bus(1'b1, 4'h0, 8'h18);
        bus(1'b1, 4'h0, 8'h21);
        rc(4'h0, 8'h29);
        bus(1'b1, 4'h0, 8'h00);
        rc(4'h0, 8'h29);
        $display("level two sequence done");
        wrap_up();
    end
endmodule
`default_nettype wire
